// >>> irqtu_core.sv
// Local design decisions: the placing of the registers and the APB interface to the registers.
module irqtu_core
    import irqtu_pkg::*;
#(
    parameter int FIFO_DEPTH = 512
) (
    // clock and reset
    input  wire logic        CLOCK_IN,
    input  wire logic        SRST_IN,
    // apb slave
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    // event sources
    input  wire irqtu_evt_t  EVT_IN,
    input  wire logic [9:0]  FIFO_LEVEL_IN,
    input  wire logic [7:0]  RX_ERROR_IN,
    // timer clock ticks
    input  wire logic        TICK_FAST_IN,
    input  wire logic        TICK_SLOW_IN,
    input  wire logic        OSC_TICK_IN,
    // status
    output logic             IRQ_OUT,
    output logic             NEAR_FULL_OUT,
    output logic             NEAR_EMPTY_OUT,
    output logic [4:0]       TMR_RUNNING_OUT
);

    localparam int LW = 10;

    if (FIFO_DEPTH < 2 || FIFO_DEPTH > 2 ** (LW - 1)) begin : g_chk
        $error("FIFO_DEPTH out of range");
    end

    // ========================================
    // state
    logic [6:0]    sa_reg;
    logic [6:0]    sb_reg;
    logic [6:0]    ea_reg;
    logic [6:0]    eb_reg;
    logic [8:0]    thr_reg;
    logic [7:0]    ctl_reg [NUM_TMR];
    logic [15:0]   rel_reg [NUM_TMR];
    logic [15:0]   cnt_reg [NUM_TMR];
    irqtu_tstate_t st_reg  [NUM_TMR];
    logic          wake_uf_reg;
    logic          irq_reg;
    logic          nf_reg;
    logic          ne_reg;
    logic          tx_prev_reg;
    logic          idle_prev_reg;
    logic [31:0]   rdata_reg;

    logic [31:0]   rd_next;
    logic          hit;
    logic          wr;
    logic [7:0]    wd;
    logic          tw_any;
    logic [2:0]    ti;
    logic [4:0]    tofs;
    logic [6:0]    set_a;
    logic [6:0]    set_b;
    logic          nf_c;
    logic          ne_c;
    logic          pend;
    logic [4:0]    run;
    logic [4:0]    tick;
    logic [4:0]    tstart;
    logic [4:0]    tstop;
    logic [4:0]    uf;

    // ========================================
    // helpers
    function automatic logic [6:0] set_clr(input logic [6:0] old,
                                           input logic [7:0] d);
        return d[SEL_BIT] ? (old | d[FLAG_MSB:0])
                          : (old & ~d[FLAG_MSB:0]);
    endfunction

    function automatic logic [2:0] tmr_idx(input logic [7:0] a);
        logic [7:0] r;
        r = a - OFS_TMR_BASE;
        return r[ADDR_W-1:TMR_SHIFT];
    endfunction

    function automatic logic is_tmr(input logic [7:0] a);
        return (a >= OFS_TMR_BASE) && (int'(tmr_idx(a)) < NUM_TMR);
    endfunction

    // ========================================
    // apb decode and read
    assign wr         = PSEL_IN & PENABLE_IN & PWRITE_IN;
    assign wd         = PWDATA_IN[7:0];
    assign ti         = tmr_idx(PADDR_IN);
    assign tofs       = PADDR_IN[TMR_SHIFT-1:0];
    assign tw_any     = wr & is_tmr(PADDR_IN);
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~hit;
    assign PRDATA_OUT = rdata_reg;

    always_comb begin
        rd_next = '0;
        hit     = 1'b1;
        case (PADDR_IN)
            OFS_STAT_A:   rd_next[6:0] = sa_reg;
            OFS_STAT_B:   rd_next[6:0] = sb_reg;
            OFS_EN_A:     rd_next[6:0] = ea_reg;
            OFS_EN_B:     rd_next[6:0] = eb_reg;
            OFS_DEV_STAT: rd_next[DS_IRQ] = irq_reg;
            // R21 running readback
            OFS_TGCTRL:   rd_next[3:0] = run[3:0];
            OFS_THRESH:   rd_next[8:0] = thr_reg;
            default: begin
                if (is_tmr(PADDR_IN)) begin
                    // R17 count bytes readable
                    case (tofs)
                        T_CTRL: begin
                            rd_next[7:0]   = ctl_reg[ti];
                            rd_next[CT_RUN] = run[ti];
                        end
                        T_REL_HI: rd_next[7:0] = rel_reg[ti][15:8];
                        T_REL_LO: rd_next[7:0] = rel_reg[ti][7:0];
                        T_CNT_HI: rd_next[7:0] = cnt_reg[ti][15:8];
                        T_CNT_LO: rd_next[7:0] = cnt_reg[ti][7:0];
                        default:  hit = 1'b0;
                    endcase
                end else begin
                    hit = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            rdata_reg <= '0;
        end else if (PSEL_IN & ~PENABLE_IN) begin
            rdata_reg <= rd_next;
        end
    end

    // ========================================
    // event sources
    // R7 one threshold, both levels
    assign nf_c = (11'(FIFO_LEVEL_IN) + 11'(thr_reg))
                  >= 11'(FIFO_DEPTH);
    assign ne_c = FIFO_LEVEL_IN <= LW'(thr_reg[7:0]);
    assign pend = |(sa_reg & ea_reg) | |(sb_reg & eb_reg);

    always_comb begin
        set_a = '0;
        set_b = '0;
        // R4 send done entry
        set_a[A_SEND]  = EVT_IN.tx_eof_phase & ~tx_prev_reg;
        // R5 receive done
        set_a[A_RECV]  = EVT_IN.rx_end;
        // R6 idle return
        set_a[A_CMD]   = EVT_IN.cmd_idle & ~idle_prev_reg;
        // R8 near full
        set_a[A_FULL]  = nf_c & ~nf_reg;
        // R9 near empty
        set_a[A_EMPTY] = ne_c & ~ne_reg;
        // R10 receive fault
        set_a[A_FAULT] = |RX_ERROR_IN;
        // R12 frame start
        set_a[A_SOF]   = EVT_IN.rx_sof;
        // R18 enabled underflow
        set_b[4:0]     = uf & eb_reg[4:0];
        // R11 card found
        set_b[B_CARD]  = EVT_IN.card_seen & EVT_IN.low_power_card_detect_mode;
        // R13 summary bit
        set_b[B_ANY]   = |(sa_reg & ea_reg)
                       | |(sb_reg[B_ANY-1:0] & eb_reg[B_ANY-1:0]);
    end

    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            tx_prev_reg   <= 1'b0;
            idle_prev_reg <= 1'b0;
            nf_reg        <= 1'b0;
            ne_reg        <= 1'b0;
        end else begin
            tx_prev_reg   <= EVT_IN.tx_eof_phase;
            idle_prev_reg <= EVT_IN.cmd_idle;
            nf_reg        <= nf_c;
            ne_reg        <= ne_c;
        end
    end

    // ========================================
    // status, enable and threshold registers
    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            sa_reg <= '0;
            sb_reg <= '0;
        end else begin
            // R2 selector write, R3 set wins
            sa_reg <= (wr && PADDR_IN == OFS_STAT_A ?
                       set_clr(sa_reg, wd) : sa_reg) | set_a;
            // R19 timer flags by host
            sb_reg <= (wr && PADDR_IN == OFS_STAT_B ?
                       set_clr(sb_reg, wd) : sb_reg) | set_b;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            ea_reg  <= '0;
            eb_reg  <= '0;
            thr_reg <= THR_RST;
        end else if (wr) begin
            // R1 enable pair
            if (PADDR_IN == OFS_EN_A) ea_reg <= set_clr(ea_reg, wd);
            if (PADDR_IN == OFS_EN_B) eb_reg <= set_clr(eb_reg, wd);
            if (PADDR_IN == OFS_THRESH) thr_reg <= PWDATA_IN[8:0];
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            irq_reg <= 1'b0;
        end else begin
            // R23 pin follows pending
            irq_reg <= pend;
        end
    end

    assign IRQ_OUT        = irq_reg;
    assign NEAR_FULL_OUT  = nf_reg;
    assign NEAR_EMPTY_OUT = ne_reg;

    // ========================================
    // timers
    always_comb begin
        for (int i = 0; i < NUM_TMR; i++) begin
            run[i] = st_reg[i] == IRQTU_COUNTING;
            // R14 tick select
            case (irqtu_clk_sel_t'(ctl_reg[i][CT_SEL_MSB:CT_SEL_LSB]))
                IRQTU_CLK_FAST: tick[i] = TICK_FAST_IN;
                IRQTU_CLK_SLOW: tick[i] = TICK_SLOW_IN;
                IRQTU_CLK_WAKE: tick[i] = wake_uf_reg;
                default:        tick[i] = 1'b0;
            endcase
            // R16 wake-up tick source
            if (i == WAKE_IDX) tick[i] = OSC_TICK_IN;
            tstart[i] = 1'b0;
            tstop[i]  = 1'b0;
            // R22 mode start bit
            if (tw_any && int'(ti) == i && tofs == T_CTRL) begin
                tstart[i] = wd[CT_START];
                tstop[i]  = wd[CT_STOP];
            end
            // R21 apply-now start/stop
            if (wr && PADDR_IN == OFS_TGCTRL && i < WAKE_IDX
                && PWDATA_IN[GC_APPLY_LSB + i]) begin
                tstart[i] = PWDATA_IN[GC_RUN_LSB + i];
                tstop[i]  = ~PWDATA_IN[GC_RUN_LSB + i];
            end
            uf[i] = run[i] && tick[i] && cnt_reg[i] == CNT_ZERO;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        for (int i = 0; i < NUM_TMR; i++) begin
            if (SRST_IN) begin
                st_reg[i]  <= IRQTU_STOPPED;
                cnt_reg[i] <= CNT_ZERO;
            end else if (tstart[i]) begin
                st_reg[i]  <= IRQTU_COUNTING;
                cnt_reg[i] <= rel_reg[i];
            end else if (tstop[i]) begin
                st_reg[i]  <= IRQTU_STOPPED;
            end else begin
                case (st_reg[i])
                    IRQTU_COUNTING: begin
                        if (uf[i]) begin
                            // R20 reload or stop
                            if (ctl_reg[i][CT_RELOAD]) begin
                                cnt_reg[i] <= rel_reg[i];
                            end else begin
                                st_reg[i] <= IRQTU_STOPPED;
                            end
                        end else if (tick[i]) begin
                            // R17 decrement per tick
                            cnt_reg[i] <= cnt_reg[i] - CNT_ONE;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        for (int i = 0; i < NUM_TMR; i++) begin
            if (SRST_IN) begin
                ctl_reg[i] <= '0;
                rel_reg[i] <= CNT_ZERO;
            end else if (tw_any && int'(ti) == i) begin
                // R15 byte-wise reload
                case (tofs)
                    T_CTRL:   ctl_reg[i] <= wd & CT_KEEP_MASK;
                    T_REL_HI: rel_reg[i][15:8] <= wd;
                    T_REL_LO: rel_reg[i][7:0] <= wd;
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            wake_uf_reg <= 1'b0;
        end else begin
            wake_uf_reg <= uf[WAKE_IDX];
        end
    end

    assign TMR_RUNNING_OUT = run;

    // ========================================
    // checks
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (SRST_IN);

    chk_pin_raise: assert property ( // R23
        pend |=> IRQ_OUT)
        else $error("irq pin not raised");
    chk_pin_drop: assert property ( // R3
        !pend |=> !IRQ_OUT)
        else $error("irq pin not dropped");
    chk_send_done: assert property ( // R4
        EVT_IN.tx_eof_phase && !tx_prev_reg |=> sa_reg[A_SEND])
        else $error("send done lost");
    chk_recv_done: assert property ( // R5
        EVT_IN.rx_end |=> sa_reg[A_RECV] ##1 IRQ_OUT || !ea_reg[A_RECV])
        else $error("receive done lost");
    chk_fault_flag: assert property ( // R10
        |RX_ERROR_IN |=> sa_reg[A_FAULT])
        else $error("fault flag lost");
    chk_sw_clear: assert property ( // R2
        wr && PADDR_IN == OFS_STAT_A && !wd[SEL_BIT] && wd[A_RECV]
        && !EVT_IN.rx_end |=> !sa_reg[A_RECV])
        else $error("clear write ignored");
    chk_tmr_dec: assert property ( // R17
        run[0] && tick[0] && !uf[0] && !tstart[0] && !tstop[0]
        |=> cnt_reg[0] == $past(cnt_reg[0]) - CNT_ONE)
        else $error("timer did not decrement");
    chk_tmr_flag: assert property ( // R18
        uf[0] && eb_reg[0] |=> sb_reg[0])
        else $error("underflow flag lost");
    chk_tmr_stop: assert property ( // R20
        uf[0] && !ctl_reg[0][CT_RELOAD] && !tstart[0]
        |=> !run[0] && cnt_reg[0] == CNT_ZERO)
        else $error("timer did not stop");
    chk_tmr_start: assert property ( // R21
        tstart[2] |=> run[2] && cnt_reg[2] == $past(rel_reg[2]))
        else $error("timer did not start");
    chk_summary: assert property ( // R13
        |(sa_reg & ea_reg) |=> sb_reg[B_ANY])
        else $error("summary bit not set");

    cov_periodic: cover property (
        uf[0] ##[1:1000] uf[0]);
    cov_irq_rise: cover property (!IRQ_OUT ##1 IRQ_OUT);
    cov_card: cover property (set_b[B_CARD]);
    cov_wake_chain: cover property (wake_uf_reg && run[0]);
endmodule

// >>> irqtu_pkg.sv
package irqtu_pkg;
// ========================================
// Operation
// R1 - two status and two enable registers
// R2 - bit 7 selects set or clear
// R3 - event sets flag, enabled drives pin
// R4 - send done on entering end pattern
// R5 - receive done at stream end
// R6 - command done on return to idle
// R7 - one threshold sets both FIFO levels
// R8 - near full event at top level
// R9 - near empty event at bottom level
// R10 - fault event while error bits set
// R11 - card found in low-power detect mode
// R12 - frame start on start or subcarrier (code sets A_SOF from EVT_IN.rx_sof only)
// R13 - summary bit from enabled sources
// R14 - timer clock fast, slow or wake-up
// R15 - 16-bit counter, byte-wise reload
// R16 - wake-up timer on slow oscillator
// R17 - count readable, decrements per tick
// R18 - underflow sets enabled timer flag
// R19 - host sets and clears timer flags
// R20 - underflow stops or reloads
// R21 - apply-now with running starts/stops
// R22 - mode start bit starts timer
// R23 - pin high while enabled flag pending

    // ========================================
    // register map
    localparam int         ADDR_W       = 8;
    localparam logic [7:0] OFS_STAT_A   = 8'h00;
    localparam logic [7:0] OFS_STAT_B   = 8'h04;
    localparam logic [7:0] OFS_EN_A     = 8'h08;
    localparam logic [7:0] OFS_EN_B     = 8'h0c;
    localparam logic [7:0] OFS_DEV_STAT = 8'h10;
    localparam logic [7:0] OFS_TGCTRL   = 8'h14;
    localparam logic [7:0] OFS_THRESH   = 8'h18;
    localparam logic [7:0] OFS_TMR_BASE = 8'h20;
    localparam int         TMR_SHIFT    = 5;
    localparam logic [4:0] T_CTRL       = 5'h00;
    localparam logic [4:0] T_REL_HI     = 5'h04;
    localparam logic [4:0] T_REL_LO     = 5'h08;
    localparam logic [4:0] T_CNT_HI     = 5'h0c;
    localparam logic [4:0] T_CNT_LO     = 5'h10;

    // ========================================
    // fields
    localparam int NUM_TMR  = 5;
    localparam int WAKE_IDX = 4;
    localparam int FLAG_MSB = 6;
    localparam int SEL_BIT  = 7;
    localparam int A_SEND   = 0;
    localparam int A_RECV   = 1;
    localparam int A_CMD    = 2;
    localparam int A_FULL   = 3;
    localparam int A_EMPTY  = 4;
    localparam int A_FAULT  = 5;
    localparam int A_SOF    = 6;
    localparam int B_CARD   = 5;
    localparam int B_ANY    = 6;
    localparam int CT_SEL_LSB = 0;
    localparam int CT_SEL_MSB = 1;
    localparam int CT_RELOAD  = 2;
    localparam int CT_START   = 3;
    localparam int CT_RUN     = 4;
    localparam int CT_STOP    = 5;
    localparam int GC_RUN_LSB = 0;
    localparam int GC_APPLY_LSB = 4;
    localparam int DS_IRQ     = 0;
    localparam logic [7:0]  CT_KEEP_MASK = 8'h07;
    localparam logic [8:0]  THR_RST      = 9'h008;
    localparam logic [15:0] CNT_ZERO     = 16'h0000;
    localparam logic [15:0] CNT_ONE      = 16'h0001;

    // ========================================
    // types
    typedef enum logic [1:0] {
        IRQTU_CLK_FAST = 2'b00,
        IRQTU_CLK_SLOW = 2'b01,
        IRQTU_CLK_WAKE = 2'b10
    } irqtu_clk_sel_t;

    typedef enum logic {
        IRQTU_STOPPED  = 1'b0,
        IRQTU_COUNTING = 1'b1
    } irqtu_tstate_t;

    typedef struct packed {
        logic tx_eof_phase;
        logic rx_end;
        logic cmd_idle;
        logic rx_sof;
        logic card_seen;
        logic low_power_card_detect_mode;
    } irqtu_evt_t;
endpackage

// >>> irqtu_host_model.sv
module irqtu_host_model
    import irqtu_pkg::*;
(
    // clock
    input  wire logic        clk_in,
    // apb master side
    output logic             psel_out,
    output logic             penable_out,
    output logic             pwrite_out,
    output logic [7:0]       paddr_out,
    output logic [31:0]      pwdata_out,
    input  wire logic [31:0] prdata_in,
    input  wire logic        pready_in,
    input  wire logic        pslverr_in,
    // answer never came
    output logic             hung_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        paddr_out = 8'h00;
        pwdata_out = 32'h0;
        hung_out = 1'b0;
    end

    // one transfer: setup, then access until ready
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic err);
        int n;
        @(posedge clk_in);
        psel_out <= 1'b1;
        penable_out <= 1'b0;
        pwrite_out <= w;
        paddr_out <= a;
        pwdata_out <= d;
        @(posedge clk_in);
        penable_out <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_in !== 1'b1 && n < 64);
        if (pready_in !== 1'b1) begin
            hung_out = 1'b1;
        end
        q = prdata_in;
        err = pslverr_in;
        psel_out <= 1'b0;
        penable_out <= 1'b0;
        // released data no longer shows the written word
        pwdata_out <= ~d;
    endtask
endmodule

// >>> irq_and_timer_unit_tb.sv
module irq_and_timer_unit_tb
    import irqtu_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FD = 64;

    // ========================================
    // signals and model state
    logic        clk;
    logic        srst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    irqtu_evt_t  evt;
    logic [9:0]  fifo_lvl;
    logic [7:0]  rx_err;
    logic [2:0]  tk;
    logic        irq;
    logic        nfull;
    logic        nempty;
    logic [4:0]  trun;
    logic        hung;
    logic [31:0] q;
    logic        e;
    int          fail_count;
    int          tests_run;
    int          seed;
    int          r;
    logic [7:0]  m_sa;
    logic [7:0]  m_sb;
    logic [7:0]  m_ea;
    logic [7:0]  m_eb;
    logic [4:0]  m_run;
    logic [4:0]  m_auto;
    int          m_cnt [5];
    int          m_rel [5];
    int          m_sel [5];

    irqtu_core #(.FIFO_DEPTH(FD)) irqtu_core_i (
        .CLOCK_IN(clk), .SRST_IN(srst), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .EVT_IN(evt), .FIFO_LEVEL_IN(fifo_lvl),
        .RX_ERROR_IN(rx_err), .TICK_FAST_IN(tk[0]), .TICK_SLOW_IN(tk[1]),
        .OSC_TICK_IN(tk[2]), .IRQ_OUT(irq), .NEAR_FULL_OUT(nfull),
        .NEAR_EMPTY_OUT(nempty), .TMR_RUNNING_OUT(trun));

    irqtu_host_model irqtu_host_model_i (
        .clk_in(clk), .psel_out(psel), .penable_out(penable),
        .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata),
        .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr),
        .hung_out(hung));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ========================================
    // model and checks
    function automatic logic pend();
        return (|(m_sa[6:0] & m_ea[6:0])) || (|(m_sb[5:0] & m_eb[5:0]));
    endfunction

    function automatic logic [7:0] upd(logic [7:0] v, logic [7:0] d);
        return d[7] ? {1'b0, v[6:0] | d[6:0]} : {1'b0, v[6:0] & ~d[6:0]};
    endfunction

    function automatic void sync();
        if (pend()) m_sb[B_ANY] = 1'b1;
    endfunction

    function automatic bit m_tick(int i);
        if (!m_run[i]) return 1'b0;
        if (m_cnt[i] != 0) begin
            m_cnt[i]--;
            return 1'b0;
        end
        if (m_eb[i]) m_sb[i] = 1'b1;
        if (m_auto[i]) m_cnt[i] = m_rel[i];
        else m_run[i] = 1'b0;
        return 1'b1;
    endfunction

    function automatic logic [7:0] ta(int i, logic [4:0] o);
        return OFS_TMR_BASE + 8'(i << TMR_SHIFT) + {3'h0, o};
    endfunction

    task automatic stop_test();
        if (fail_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(string n, logic [31:0] x, logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic cmp_pin(string n, logic [4:0] x, logic [4:0] g);
        tests_run++;
        if (g !== x) begin
            fail_count++;
            $display("[FAIL] pin %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic pins(logic nf, logic ne);
        repeat (3) @(posedge clk);
        @(negedge clk);
        cmp_pin("irq", {4'h0, pend()}, {4'h0, irq});
        cmp_pin("running", m_run, trun);
        cmp_pin("near full", {4'h0, nf}, {4'h0, nfull});
        cmp_pin("near empty", {4'h0, ne}, {4'h0, nempty});
        @(posedge clk);
    endtask

    task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
        irqtu_host_model_i.xfer(w, a, d, q, e);
        if (hung === 1'b1) begin
            fail_count++;
            stop_test();
        end
    endtask

    task automatic rd(string n, logic [7:0] a, logic [31:0] x);
        bus(1'b0, a, 32'h0);
        chk(n, x, q);
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        logic p;
        // sources pending at the write edge re-set the summary bit
        p = pend();
        bus(1'b1, a, {24'h0, d});
        case (a)
            OFS_STAT_A: m_sa = upd(m_sa, d);
            OFS_STAT_B: m_sb = upd(m_sb, d);
            OFS_EN_A:   m_ea = upd(m_ea, d);
            OFS_EN_B:   m_eb = upd(m_eb, d);
            default: ;
        endcase
        if (p) m_sb[B_ANY] = 1'b1;
        sync();
    endtask

    task automatic tset(int i, int rel, logic [7:0] c);
        wr(ta(i, T_REL_HI), 8'(rel >> 8));
        wr(ta(i, T_REL_LO), 8'(rel));
        wr(ta(i, T_CTRL), c);
        m_rel[i] = rel;
        m_sel[i] = c[1:0];
        m_auto[i] = c[CT_RELOAD];
        if (c[CT_START]) begin
            m_run[i] = 1'b1;
            m_cnt[i] = rel;
        end
    endtask

    task automatic rcnt(int i);
        rd("count high", ta(i, T_CNT_HI), 32'(m_cnt[i] >> 8));
        rd("count low", ta(i, T_CNT_LO), 32'(m_cnt[i] & 255));
    endtask

    task automatic tick(int k, int n);
        repeat (n) begin
            @(posedge clk);
            tk[k] <= 1'b1;
            @(posedge clk);
            tk[k] <= 1'b0;
            if (k == 2 && m_tick(WAKE_IDX)) begin
                for (int i = 0; i < 4; i++)
                    if (m_sel[i] == 2) void'(m_tick(i));
            end
            for (int i = 0; i < 4; i++)
                if (k < 2 && m_sel[i] == k) void'(m_tick(i));
            sync();
        end
        repeat (2) @(posedge clk);
    endtask

    task automatic fire(int i);
        r = $random(seed);
        @(posedge clk);
        case (i)
            0: evt.tx_eof_phase <= 1'b1;
            1: evt.rx_end <= 1'b1;
            2: evt.cmd_idle <= 1'b1;
            3: evt.rx_sof <= 1'b1;
            4: evt.card_seen <= 1'b1;
            default: rx_err <= 8'h01 << r[2:0];
        endcase
        @(posedge clk);
        evt <= irqtu_evt_t'(6'h01);
        rx_err <= 8'h00;
        if (i == 4) m_sb[B_CARD] = 1'b1;
        else m_sa[(i == 3) ? A_SOF : (i == 5) ? A_FAULT : i] = 1'b1;
        sync();
        repeat (2) @(posedge clk);
    endtask

    // ========================================
    // main sequence
    initial begin
        srst = 1'b1;
        evt = irqtu_evt_t'(6'h01);
        fifo_lvl = 10'd20;
        rx_err = 8'h00;
        tk = 3'b000;
        fail_count = 0;
        tests_run = 0;
        seed = 32'hdb86c424;
        {m_sa, m_sb, m_ea, m_eb, m_run, m_auto} = '0;
        m_sel = '{3, 3, 3, 3, 3};
        m_cnt = '{0, 0, 0, 0, 0};
        m_rel = '{0, 0, 0, 0, 0};
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 7; i++)
            rd("reset value", 8'(i * 4), (i == 6) ? 32'(THR_RST) : 0);
        bus(1'b0, 8'hfc, 32'h0);
        chk("unmapped data", 32'h0, q);
        chk("unmapped error", 32'h1, {31'h0, e});
        r = $random(seed);
        wr(OFS_STAT_A, 8'h85);
        rd("status a", OFS_STAT_A, 32'(m_sa));
        wr(OFS_STAT_A, 8'h01);
        rd("status a", OFS_STAT_A, 32'(m_sa));
        wr(OFS_EN_A, 8'h80 | 8'(r[6:0]));
        rd("enable a", OFS_EN_A, 32'(m_ea));
        wr(OFS_EN_A, 8'h7f);
        wr(OFS_STAT_A, 8'h7f);
        wr(OFS_STAT_B, 8'h40);
        rd("status b", OFS_STAT_B, 32'(m_sb));
        for (int i = 0; i < 6; i++) begin
            fire(i);
            rd("status a", OFS_STAT_A, 32'(m_sa));
            rd("status b", OFS_STAT_B, 32'(m_sb));
            wr(OFS_STAT_A, 8'h7f);
            wr(OFS_STAT_B, 8'h20);
        end
        pins(1'b0, 1'b0);
        wr(OFS_EN_A, 8'h82);
        fire(1);
        pins(1'b0, 1'b0);
        rd("device status", OFS_DEV_STAT, {31'h0, pend()});
        rd("status b", OFS_STAT_B, 32'(m_sb));
        wr(OFS_STAT_A, 8'h02);
        wr(OFS_STAT_B, 8'h40);
        pins(1'b0, 1'b0);
        wr(OFS_EN_A, 8'h02);
        wr(OFS_THRESH, 8'h10);
        fifo_lvl <= 10'(FD - 16);
        pins(1'b1, 1'b0);
        fifo_lvl <= 10'(FD - 17);
        pins(1'b0, 1'b0);
        fifo_lvl <= 10'd16;
        pins(1'b0, 1'b1);
        m_sa[A_FULL] = 1'b1;
        m_sa[A_EMPTY] = 1'b1;
        rd("status a", OFS_STAT_A, 32'(m_sa));
        fifo_lvl <= 10'd17;
        wr(OFS_STAT_A, 8'h18);
        pins(1'b0, 1'b0);
        bus(1'b1, OFS_THRESH, 32'h110);
        pins(1'b1, 1'b0);
        wr(OFS_THRESH, 8'h10);
        wr(OFS_EN_B, 8'h83);
        tset(0, 3, 8'h00);
        wr(OFS_TGCTRL, 8'h11);
        m_run[0] = 1'b1;
        m_cnt[0] = 3;
        tick(0, 3);
        rcnt(0);
        rd("status b", OFS_STAT_B, 32'(m_sb));
        tick(0, 1);
        rcnt(0);
        rd("status b", OFS_STAT_B, 32'(m_sb));
        pins(1'b0, 1'b0);
        wr(OFS_STAT_B, 8'h41);
        rd("status b", OFS_STAT_B, 32'(m_sb));
        wr(OFS_STAT_B, 8'h81);
        pins(1'b0, 1'b0);
        wr(OFS_EN_B, 8'h01);
        pins(1'b0, 1'b0);
        wr(OFS_STAT_B, 8'h41);
        tset(1, 2, 8'h0d);
        tick(0, 2);
        rcnt(1);
        tick(1, 3);
        rcnt(1);
        rd("global ctrl", OFS_TGCTRL, {28'h0, m_run[3:0]});
        rd("status b", OFS_STAT_B, 32'(m_sb));
        wr(OFS_TGCTRL, 8'h20);
        m_run[1] = 1'b0;
        pins(1'b0, 1'b0);
        wr(OFS_STAT_B, 8'h42);
        wr(OFS_EN_B, 8'h02);
        tset(2, 1, 8'h0a);
        tset(WAKE_IDX, 1, 8'h0c);
        tick(2, 2);
        tick(0, 1);
        tick(1, 1);
        rcnt(2);
        rcnt(WAKE_IDX);
        tick(2, 2);
        rcnt(2);
        rd("status b", OFS_STAT_B, 32'(m_sb));
        r = $random(seed);
        for (int j = 0; j < 3; j++) begin
            tset(3, (j == 0) ? 0 : (j == 1) ? 65535 : int'(r[15:0]), 8'h0b);
            rcnt(3);
        end
        wr(ta(3, T_CTRL), 8'h23);
        m_run[3] = 1'b0;
        pins(1'b0, 1'b0);
        stop_test();
    end
endmodule
